// ==== hdl/bwd_byte_half.sv ====
// One byte-wide half of the word storage.
// Assumes write controls are already qualified by the caller.
module bwd_byte_half (
    input wire logic clock,
    input wire logic we,
    input wire bwd_pkg::bwd_idx_t w_idx,
    input wire bwd_pkg::bwd_byte_t w_data,
    input wire bwd_pkg::bwd_idx_t x_idx,
    input wire bwd_pkg::bwd_idx_t y_idx,
    output bwd_pkg::bwd_byte_t x_data,
    output bwd_pkg::bwd_byte_t y_data
);
    import bwd_pkg::*;

    // Storage content is data, so no reset
    bwd_byte_t mem [BWD_MEM_WORDS];

    always_ff @(posedge clock) begin
        if (we) begin
            mem[w_idx] <= w_data;
        end
    end

    assign x_data = mem[x_idx];
    assign y_data = mem[y_idx];

endmodule : bwd_byte_half

// ==== hdl/bwd_data_access.sv ====
// Byte/word data access: lane select, lane writes, pointer step, traps.
// Assumes the core holds each request one cycle and signals the end
// of every instruction on instr_done.
//
// Summary of operation
// - Storage is word organised; every effective address names one byte.
// - Byte read fetches the whole word; address bit 0 picks the byte.
// - The picked byte is returned on the low lane of the X path.
// - Secondary Y read path returns whole words only, never bytes.
// - Two byte halves share one word decoder, each with own write enable.
// - Byte write changes only the addressed half of the word.
// - Post-increment adds one for byte and two for word operations.
// - A word access at an odd address raises an address error trap.
// - On a misaligned read the instruction still completes.
// - On a misaligned write the instruction runs but nothing is stored.
// - Trap is taken after the instruction ends; prior state is kept.
// - Effective addresses are 16-bit byte addresses, 64 Kbyte space.
// - Data word and internal registers are 16 bits wide.
// - Reads of unimplemented addresses return all zeros.
module bwd_data_access (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic x_req,
    input wire logic x_we,
    input wire logic x_byte,
    input wire logic x_post_inc,
    input wire bwd_pkg::bwd_word_t source_pointer_register,
    input wire bwd_pkg::bwd_word_t x_wdata,
    input wire logic y_req,
    input wire bwd_pkg::bwd_word_t y_addr,
    input wire logic instr_done,
    output bwd_pkg::bwd_word_t x_rdata,
    output logic x_rvalid,
    output bwd_pkg::bwd_word_t y_rdata,
    output logic y_rvalid,
    output bwd_pkg::bwd_word_t ptr_next,
    output logic ptr_next_valid,
    output logic addr_err_trap,
    output logic fault_pending,
    output bwd_pkg::bwd_word_t fault_addr
);
    import bwd_pkg::*;

    // ****************************************
    // Address generation
    // ****************************************
    bwd_word_t x_ea;
    bwd_word_t step_ptr;
    logic x_odd;

    bwd_ptr_step u_step (
        .ptr(source_pointer_register),
        .byte_op(x_byte),
        .ea(x_ea),
        .next_ptr(step_ptr),
        .misaligned(x_odd)
    );

    logic x_fault;
    logic y_fault;
    logic fault_now;

    assign x_fault = x_req & x_odd;
    // Y path is word-only, so any odd address is misaligned
    assign y_fault = y_req & y_addr[0];
    assign fault_now = x_fault | y_fault;

    // ****************************************
    // Byte halves and write lanes
    // ****************************************
    logic x_wr;
    logic lo_we;
    logic hi_we;
    bwd_byte_t lo_wdata;
    bwd_byte_t hi_wdata;
    bwd_idx_t x_idx;
    bwd_idx_t y_idx;
    bwd_byte_t x_lo;
    bwd_byte_t x_hi;
    bwd_byte_t y_lo;
    bwd_byte_t y_hi;

    // Misaligned word writes never reach storage
    assign x_wr = x_req & x_we & ~x_odd & bwd_is_impl(x_ea);
    assign lo_we = x_wr & (~x_byte | ~x_ea[0]);
    assign hi_we = x_wr & (~x_byte | x_ea[0]);
    assign lo_wdata = x_wdata[7:0];
    // Byte data arrives low; copy it to the upper lane too
    assign hi_wdata = x_byte ? x_wdata[7:0] : x_wdata[15:8];
    assign x_idx = bwd_word_idx(x_ea);
    assign y_idx = bwd_word_idx(y_addr);

    bwd_byte_half u_lo (
        .clock(clock),
        .we(lo_we),
        .w_idx(x_idx),
        .w_data(lo_wdata),
        .x_idx(x_idx),
        .y_idx(y_idx),
        .x_data(x_lo),
        .y_data(y_lo)
    );

    bwd_byte_half u_hi (
        .clock(clock),
        .we(hi_we),
        .w_idx(x_idx),
        .w_data(hi_wdata),
        .x_idx(x_idx),
        .y_idx(y_idx),
        .x_data(x_hi),
        .y_data(y_hi)
    );

    // ****************************************
    // Read paths
    // ****************************************
    bwd_word_t x_word;
    bwd_word_t y_word;
    bwd_word_t next_x_rdata;
    bwd_word_t next_y_rdata;
    logic next_x_rvalid;
    logic next_y_rvalid;

    assign x_word = bwd_is_impl(x_ea) ? {x_hi, x_lo} : BWD_ZERO_WORD;
    assign y_word = bwd_is_impl(y_addr) ? {y_hi, y_lo} : BWD_ZERO_WORD;

    always_comb begin
        next_x_rdata = x_rdata;
        next_x_rvalid = 1'b0;
        next_y_rdata = y_rdata;
        next_y_rvalid = 1'b0;
        // A misaligned read still returns data so the op completes
        if (x_req & ~x_we) begin
            next_x_rvalid = 1'b1;
            if (x_byte) begin
                next_x_rdata = {BWD_ZERO_BYTE,
                                x_ea[0] ? x_word[15:8] : x_word[7:0]};
            end else begin
                next_x_rdata = x_word;
            end
        end
        if (y_req) begin
            next_y_rvalid = 1'b1;
            next_y_rdata = y_word;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            x_rdata <= BWD_ZERO_WORD;
            x_rvalid <= 1'b0;
            y_rdata <= BWD_ZERO_WORD;
            y_rvalid <= 1'b0;
        end else begin
            x_rdata <= next_x_rdata;
            x_rvalid <= next_x_rvalid;
            y_rdata <= next_y_rdata;
            y_rvalid <= next_y_rvalid;
        end
    end

    // ****************************************
    // Pointer update
    // ****************************************
    bwd_word_t next_ptr_next;
    logic next_ptr_next_valid;

    always_comb begin
        next_ptr_next = ptr_next;
        next_ptr_next_valid = 1'b0;
        // Pointer moves even on a fault; the core decides to keep it
        if (x_req & x_post_inc) begin
            next_ptr_next = step_ptr;
            next_ptr_next_valid = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ptr_next <= BWD_ZERO_WORD;
            ptr_next_valid <= 1'b0;
        end else begin
            ptr_next <= next_ptr_next;
            ptr_next_valid <= next_ptr_next_valid;
        end
    end

    // ****************************************
    // Address error trap
    // ****************************************
    bwd_fault_e fault_state;
    bwd_fault_e next_fault_state;
    bwd_word_t next_fault_addr;
    logic next_trap;

    always_comb begin
        next_fault_state = fault_state;
        next_fault_addr = fault_addr;
        next_trap = 1'b0;
        // First fault of an instruction keeps its address
        if (fault_now && fault_state == BWD_FAULT_IDLE) begin
            next_fault_addr = x_fault ? x_ea : y_addr;
        end
        unique case (fault_state)
            BWD_FAULT_IDLE: begin
                if (fault_now) begin
                    next_fault_state = BWD_FAULT_PEND;
                end
            end
            BWD_FAULT_PEND: begin
                next_fault_state = BWD_FAULT_PEND;
            end
        endcase
        // Fault in the last cycle still belongs to this instruction
        if (instr_done && (fault_now || fault_state == BWD_FAULT_PEND)) begin
            next_trap = 1'b1;
            next_fault_state = BWD_FAULT_IDLE;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fault_state <= BWD_FAULT_IDLE;
            fault_addr <= BWD_ZERO_WORD;
            addr_err_trap <= 1'b0;
            fault_pending <= 1'b0;
        end else begin
            fault_state <= next_fault_state;
            fault_addr <= next_fault_addr;
            addr_err_trap <= next_trap;
            fault_pending <= (next_fault_state == BWD_FAULT_PEND);
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    sequence seq_odd_word;
        x_req && !x_byte && source_pointer_register[0];
    endsequence

    sequence seq_trap_seen;
        ##1 (fault_pending || addr_err_trap);
    endsequence

    AST_BYTE_LOW_LANE: assert property (
        (x_req && !x_we && x_byte) |=> (x_rdata[15:8] == 8'h00))
        else $error("byte read left upper lane non-zero");

    AST_UNIMPL_ZERO: assert property (
        (x_req && !x_we && !bwd_is_impl(x_ea)) |=> (x_rdata == 16'h0000))
        else $error("unimplemented read not zero");

    AST_BYTE_STEP: assert property (
        (x_req && x_post_inc && x_byte)
        |=> (ptr_next_valid
             && ptr_next == $past(source_pointer_register) + 16'h0001))
        else $error("byte pointer step not one");

    AST_WORD_STEP: assert property (
        (x_req && x_post_inc && !x_byte)
        |=> (ptr_next == $past(source_pointer_register) + 16'h0002))
        else $error("word pointer step not two");

    AST_ODD_WORD_TRAPS: assert property (
        seq_odd_word |-> seq_trap_seen)
        else $error("odd word access raised no fault");

    AST_MISREAD_COMPLETES: assert property (
        (seq_odd_word and (!x_we)) |=> x_rvalid)
        else $error("misaligned read did not complete");

    AST_MISWRITE_BLOCKED: assert property (
        (seq_odd_word and x_we) |-> (!lo_we && !hi_we))
        else $error("misaligned write reached storage");

    AST_BYTE_ONE_LANE: assert property (
        (x_byte) |-> !(lo_we && hi_we) && !(hi_we && !x_ea[0])
                     && !(lo_we && x_ea[0]))
        else $error("byte write touched wrong lane");

    AST_TRAP_AFTER_DONE: assert property (
        addr_err_trap |-> ($past(instr_done) && !fault_pending))
        else $error("trap not aligned to instruction end");

    AST_Y_FULL_WORD: assert property (
        (y_req && bwd_is_impl(y_addr))
        |=> (y_rdata == $past({y_hi, y_lo})))
        else $error("Y path returned partial word");

    AST_FAULT_ADDR_HELD: assert property (
        fault_pending |=> $stable(fault_addr))
        else $error("fault address changed while pending");

endmodule : bwd_data_access

// ==== hdl/bwd_ptr_step.sv ====
// Effective address and post-increment for a register-indirect pointer.
// Assumes the pointer value is supplied by the core's register file.
module bwd_ptr_step (
    input wire bwd_pkg::bwd_word_t ptr,
    input wire logic byte_op,
    output bwd_pkg::bwd_word_t ea,
    output bwd_pkg::bwd_word_t next_ptr,
    output logic misaligned
);
    import bwd_pkg::*;

    assign ea = ptr;
    // Step scales with operand size
    assign next_ptr = ptr + (byte_op ? BWD_STEP_BYTE : BWD_STEP_WORD);
    assign misaligned = ~byte_op & ptr[0];

endmodule : bwd_ptr_step

// ==== include/bwd_pkg.sv ====
// Constants, types and helpers for the byte/word data access block.
// Assumes a 16-bit core with byte effective addresses.
package bwd_pkg;

    // ****************************************
    // Widths and memory placement
    // ****************************************
    localparam int BWD_WORD_W = 16;
    localparam int BWD_BYTE_W = 8;
    localparam int BWD_IDX_W = 8;
    localparam int BWD_MEM_WORDS = 256;
    localparam logic [15:0] BWD_MEM_BASE = 16'h0800;
    localparam logic [15:0] BWD_MEM_LIMIT = 16'h0A00;

    // ****************************************
    // Steps and reset values
    // ****************************************
    localparam logic [15:0] BWD_STEP_BYTE = 16'h0001;
    localparam logic [15:0] BWD_STEP_WORD = 16'h0002;
    localparam logic [15:0] BWD_ZERO_WORD = 16'h0000;
    localparam logic [7:0] BWD_ZERO_BYTE = 8'h00;

    typedef logic [BWD_WORD_W-1:0] bwd_word_t;
    typedef logic [BWD_BYTE_W-1:0] bwd_byte_t;
    typedef logic [BWD_IDX_W-1:0] bwd_idx_t;

    typedef enum logic [0:0] {
        BWD_FAULT_IDLE = 1'b0,
        BWD_FAULT_PEND = 1'b1
    } bwd_fault_e;

    // Address falls inside implemented storage
    function automatic logic bwd_is_impl(input bwd_word_t a);
        return (a >= BWD_MEM_BASE) && (a < BWD_MEM_LIMIT);
    endfunction : bwd_is_impl

    // Shared word decode for both byte halves
    function automatic bwd_idx_t bwd_word_idx(input bwd_word_t a);
        bwd_word_t off;
        off = a - BWD_MEM_BASE;
        return off[BWD_IDX_W:1];
    endfunction : bwd_word_idx

endpackage : bwd_pkg

// ==== verif/bwd_core_model.sv ====
// Core-side model: address generator and pipeline strobes for the block.
// Assumes the bench calls cycle() only after reset has been released.
module bwd_core_model (
    input wire logic clock,
    output logic x_req,
    output logic x_we,
    output logic x_byte,
    output logic x_post_inc,
    output bwd_pkg::bwd_word_t source_pointer_register,
    output bwd_pkg::bwd_word_t x_wdata,
    output logic y_req,
    output bwd_pkg::bwd_word_t y_addr,
    output logic instr_done
);
    timeunit 1ns;
    timeprecision 1ps;
    import bwd_pkg::*;

    // ****************************************
    // Idle levels
    // ****************************************
    initial begin
        x_req = 1'b0;
        x_we = 1'b0;
        x_byte = 1'b0;
        x_post_inc = 1'b0;
        source_pointer_register = 16'h0000;
        x_wdata = 16'h0000;
        y_req = 1'b0;
        y_addr = 16'h0000;
        instr_done = 1'b0;
    end

    // ****************************************
    // One request cycle, then release
    // ****************************************
    // Odd word pointers only where a scenario asks for a fault
    task automatic cycle(input logic xr, we, by, inc, bwd_word_t p, wd,
                         input logic yr, bwd_word_t ya, input logic dn);
        @(posedge clock);
        x_req <= xr;
        x_we <= we;
        x_byte <= by;
        x_post_inc <= inc;
        source_pointer_register <= p;
        x_wdata <= wd;
        y_req <= yr;
        y_addr <= ya;
        instr_done <= dn;
        @(posedge clock);
        x_req <= 1'b0;
        x_we <= 1'b0;
        x_byte <= 1'b0;
        x_post_inc <= 1'b0;
        instr_done <= 1'b0;
        y_req <= 1'b0;
        // Released lines toggle so stale values cannot pass
        source_pointer_register <= ~p;
        x_wdata <= ~wd;
        y_addr <= ~ya;
    endtask : cycle
endmodule : bwd_core_model

// ==== verif/bwd_data_access_tb_top.sv ====
// Self-checking bench for the byte/word data access block.
// Assumes the core model drives every design input except clock and rst_b.
module bwd_data_access_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import bwd_pkg::*;

    logic clock;
    logic rst_b;
    logic x_req, x_we, x_byte, x_post_inc, y_req, instr_done;
    bwd_word_t ptr, x_wdata, y_addr, x_rdata, y_rdata, ptr_next, fault_addr;
    logic x_rvalid, y_rvalid, ptr_next_valid, addr_err_trap, fault_pending;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;

    bwd_core_model core (.clock(clock), .x_req(x_req), .x_we(x_we),
        .x_byte(x_byte), .x_post_inc(x_post_inc),
        .source_pointer_register(ptr), .x_wdata(x_wdata), .y_req(y_req),
        .y_addr(y_addr), .instr_done(instr_done));

    bwd_data_access dut (.clock(clock), .rst_b(rst_b), .x_req(x_req),
        .x_we(x_we), .x_byte(x_byte), .x_post_inc(x_post_inc),
        .source_pointer_register(ptr), .x_wdata(x_wdata), .y_req(y_req),
        .y_addr(y_addr), .instr_done(instr_done), .x_rdata(x_rdata),
        .x_rvalid(x_rvalid), .y_rdata(y_rdata), .y_rvalid(y_rvalid),
        .ptr_next(ptr_next), .ptr_next_valid(ptr_next_valid),
        .addr_err_trap(addr_err_trap), .fault_pending(fault_pending),
        .fault_addr(fault_addr));

    // ****************************************
    // Clock, timeout, helpers
    // ****************************************
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Whole run needs well under 200 cycles
    always @(posedge clock) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            give_verdict();
        end
    end

    task automatic chk(input bwd_word_t got, input bwd_word_t exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic xa(input logic we, by, inc, bwd_word_t p, wd);
        core.cycle(1'b1, we, by, inc, p, wd, 1'b0, 16'h0000, 1'b0);
        @(negedge clock);
    endtask : xa

    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_word();
        xa(1'b1, 1'b0, 1'b1, 16'h0800, 16'hA55A);
        chk(ptr_next, 16'h0802);
        chk({15'h0000, ptr_next_valid}, 16'h0001);
        xa(1'b0, 1'b0, 1'b0, 16'h0800, 16'h0000);
        chk({15'h0000, x_rvalid}, 16'h0001);
        chk(x_rdata, 16'hA55A);
        $display("test word done");
    endtask : t_word

    task automatic t_byte();
        // Upper bits of write data must not leak into the odd half
        xa(1'b1, 1'b0, 1'b0, 16'h0802, 16'h55FF);
        xa(1'b1, 1'b1, 1'b1, 16'h0803, 16'h77C3);
        chk(ptr_next, 16'h0804);
        xa(1'b0, 1'b0, 1'b0, 16'h0802, 16'h0000);
        chk(x_rdata, 16'hC3FF);
        xa(1'b1, 1'b1, 1'b0, 16'h0800, 16'hFF3C);
        xa(1'b0, 1'b0, 1'b0, 16'h0800, 16'h0000);
        chk(x_rdata, 16'hA53C);
        xa(1'b0, 1'b1, 1'b0, 16'h0801, 16'h0000);
        chk(x_rdata, 16'h00A5);
        $display("test byte done");
    endtask : t_byte

    task automatic t_y();
        core.cycle(1'b1, 1'b0, 1'b1, 1'b0, 16'h0802, 16'h0000, 1'b1, 16'h0802,
                   1'b0);
        @(negedge clock);
        chk(x_rdata, 16'h00FF);
        chk({15'h0000, y_rvalid}, 16'h0001);
        chk(y_rdata, 16'hC3FF);
        $display("test y done");
    endtask : t_y

    task automatic t_unimpl();
        // 0x0A00 would alias word 0 if the range gate were missing
        xa(1'b1, 1'b0, 1'b0, 16'h0A00, 16'hDEAD);
        xa(1'b0, 1'b0, 1'b0, 16'h0800, 16'h0000);
        chk(x_rdata, 16'hA53C);
        xa(1'b0, 1'b0, 1'b0, 16'h0A00, 16'h0000);
        chk(x_rdata, 16'h0000);
        xa(1'b0, 1'b1, 1'b0, 16'hFFFF, 16'h0000);
        chk(x_rdata, 16'h0000);
        $display("test unimpl done");
    endtask : t_unimpl

    task automatic t_trap();
        xa(1'b1, 1'b0, 1'b0, 16'h0804, 16'h1234);
        xa(1'b1, 1'b0, 1'b1, 16'h0805, 16'hBEEF);
        chk(ptr_next, 16'h0807);
        chk({15'h0000, fault_pending}, 16'h0001);
        chk({15'h0000, addr_err_trap}, 16'h0000);
        chk(fault_addr, 16'h0805);
        xa(1'b0, 1'b0, 1'b0, 16'h0805, 16'h0000);
        chk({15'h0000, x_rvalid}, 16'h0001);
        chk(x_rdata, 16'h1234);
        chk(fault_addr, 16'h0805);
        // Later odd Y fault must not replace the held address
        core.cycle(1'b0, 1'b0, 1'b0, 1'b0, 16'h0000, 16'h0000, 1'b1,
                   16'h0803, 1'b1);
        @(negedge clock);
        chk({15'h0000, addr_err_trap}, 16'h0001);
        chk({15'h0000, fault_pending}, 16'h0000);
        chk(fault_addr, 16'h0805);
        @(negedge clock);
        chk({15'h0000, addr_err_trap}, 16'h0000);
        // Odd Y fetch together with instruction end traps at once
        core.cycle(1'b0, 1'b0, 1'b0, 1'b0, 16'h0000, 16'h0000, 1'b1,
                   16'h0803, 1'b1);
        @(negedge clock);
        chk({15'h0000, addr_err_trap}, 16'h0001);
        chk(y_rdata, 16'hC3FF);
        chk(fault_addr, 16'h0803);
        $display("test trap done");
    endtask : t_trap

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst_b = 1'b0;
        repeat (8) @(posedge clock);
        @(negedge clock);
        chk({11'h000, x_rvalid, y_rvalid, ptr_next_valid, addr_err_trap,
             fault_pending}, 16'h0000);
        @(posedge clock);
        rst_b <= 1'b1;
        t_word();
        t_byte();
        t_y();
        t_unimpl();
        t_trap();
        give_verdict();
    end
endmodule : bwd_data_access_tb_top
